// >>> verilog/acs_uart_core.sv
// Asynchronous serial channel: framing, parity, wakeup and rx descriptor
// ********
// Functional notes
// (RULE1) Hunt command suspends receiver until wakeup
// (RULE2) Hunt mid-message aborts it, waits idle
// (RULE3) Mode register 16 bits, cleared by reset
// (RULE4) Tx parity: odd, zero, even, one
// (RULE5) Rx parity sense odd/even, flag violations
// (RULE6) Parity enable adds and checks parity
// (RULE7) Mode 00 wakes on idle string
// (RULE8) Multidrop transmits extra address bit
// (RULE9) Address wakeup when last bit is one
// (RULE10) Software sets wakeup mode before hunting
// (RULE11) Full buffer with irq bit sets event
// (RULE12) Control character status on final byte
// (RULE13) Mode 01 marks first byte address
// (RULE14) Auto multidrop drops matched address character
// (RULE15) Match status tells which register hit
// (RULE16) Idle count closes buffer, idle status
// (RULE17) Break during reception sets break status
// (RULE18) Missing stop bit: framing status, last byte
// (RULE19) Bad parity: store last, parity status
// (RULE20) Overrun during message sets overrun status
// (RULE21) Break is all zeros without stop
// (RULE22) Suspended receiver stores and reports nothing
// ********
//
// Implementation choices: the APB slave port and the placing of the registers.
`default_nettype none
`include "acs_regs.svh"
module acs_uart_core import acs_pkg::*; (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic rxd,
    output logic txd
);

// ********
// Registers and bus
// ********
logic [15:0] mode_ff;
logic [7:0] match_first_ff;
logic [7:0] match_second_ff;
logic [15:0] idle_close_count_ff;
logic [8:0] ctrl_char_ff;
logic [7:0] desc_ctl_ff;
logic [15:0] div_ff;
logic pready_ff;
logic pslverr_ff;
logic [31:0] prdata_ff;
logic acc;
logic wr;
logic setup;
logic buf_hit;
logic mapped;
logic [31:0] rd_data;

assign setup = psel & ~penable;
assign acc = psel & penable & pready_ff;
assign wr = acc & pwrite;
assign buf_hit = (paddr >= `ACS_A_BUF_LO) && (paddr <= `ACS_A_BUF_HI)
    && (paddr[1:0] == 2'b00);
assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;

// ********
// Line synchroniser
// ********
logic rx_s1_ff;
logic rx_s2_ff;
logic rx_s3_ff;
logic rx_ff;

// Level accepted only when second and third stage agree
always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        rx_s1_ff <= 1'b1;
        rx_s2_ff <= 1'b1;
        rx_s3_ff <= 1'b1;
        rx_ff <= 1'b1;
    end else if (ce) begin
        rx_s1_ff <= rxd;
        rx_s2_ff <= rx_s1_ff;
        rx_s3_ff <= rx_s2_ff;
        if (rx_s2_ff == rx_s3_ff) begin
            rx_ff <= rx_s3_ff;
        end
    end
end

// ********
// Character format
// ********
logic [1:0] um;
logic parity_enable;
logic [3:0] dlen;
logic [3:0] rx_bits;
logic [3:0] frame_len;

assign um = mode_ff[`ACS_UM_HI:`ACS_UM_LO];
assign parity_enable = mode_ff[`ACS_PEN];
assign dlen = mode_ff[`ACS_CL] ? 4'h8 : 4'h7;
assign rx_bits = 4'(dlen + {3'b000, um[0]} + {3'b000, parity_enable}); // see (RULE6)
// Start, data, address, parity, stops: 9 to 13 bits
assign frame_len = 4'(rx_bits + 4'h2 + {3'b000, mode_ff[`ACS_SL]});

// ********
// Receiver
// ********
acs_rx_state_t rx_st_ff;
logic [15:0] rbaud_ff;
logic [3:0] rcnt_ff;
logic [3:0] idle_bits_ff;
logic [11:0] sh_ff;
logic char_done_ff;
logic idle_seq_ff;
logic [7:0] ch_data_ff;
logic ch_abit_ff;
logic ch_perr_ff;
logic ch_ferr_ff;
logic ch_brk_ff;
logic rtick;
logic [7:0] rx_data;
logic rx_par;

assign rtick = (rbaud_ff == 16'h0000);
assign rx_data = mode_ff[`ACS_CL] ? sh_ff[7:0] : {1'b0, sh_ff[6:0]};
assign rx_par = sh_ff[4'(dlen + {3'b000, um[0]})];

always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        rx_st_ff <= R_IDLE;
        rbaud_ff <= 16'h0000;
        rcnt_ff <= 4'h0;
        idle_bits_ff <= 4'h0;
        sh_ff <= 12'h000;
        char_done_ff <= 1'b0;
        idle_seq_ff <= 1'b0;
        ch_data_ff <= 8'h00;
        ch_abit_ff <= 1'b0;
        ch_perr_ff <= 1'b0;
        ch_ferr_ff <= 1'b0;
        ch_brk_ff <= 1'b0;
    end else if (ce) begin
        char_done_ff <= 1'b0;
        idle_seq_ff <= 1'b0;
        rbaud_ff <= rtick ? div_ff : rbaud_ff - 16'h0001;
        case (rx_st_ff)
            R_IDLE: begin
                if (mode_ff[`ACS_RXEN] && !rx_ff) begin
                    rx_st_ff <= R_START;
                    rbaud_ff <= {1'b0, div_ff[15:1]};
                    idle_bits_ff <= 4'h0;
                    sh_ff <= 12'h000;
                end else if (!rx_ff || (wr && paddr == `ACS_A_CMD &&
                             pwdata[`ACS_CMD_RESYNC])) begin
                    // Hunt wants a whole fresh idle frame
                    idle_bits_ff <= 4'h0;
                end else if (rtick) begin
                    // One idle character is a full frame of ones
                    if (idle_bits_ff == 4'(frame_len - 4'h1)) begin
                        idle_seq_ff <= 1'b1; // see (RULE7)
                        idle_bits_ff <= 4'h0;
                    end else begin
                        idle_bits_ff <= idle_bits_ff + 4'h1;
                    end
                end
            end
            R_START: begin
                if (rtick) begin
                    // Glitch shorter than half a bit is not a start
                    rx_st_ff <= rx_ff ? R_IDLE : R_BITS;
                    rcnt_ff <= 4'h0;
                end
            end
            R_BITS: begin
                if (rtick) begin
                    sh_ff[rcnt_ff] <= rx_ff;
                    rcnt_ff <= rcnt_ff + 4'h1;
                    if (rcnt_ff == 4'(rx_bits - 4'h1)) begin
                        rx_st_ff <= R_STOP;
                    end
                end
            end
            R_STOP: begin
                if (rtick) begin
                    char_done_ff <= 1'b1;
                    ch_data_ff <= rx_data;
                    ch_abit_ff <= um[0] & sh_ff[dlen]; // see (RULE9)
                    ch_perr_ff <= parity_enable &
                        ((^rx_data ^ rx_par) == mode_ff[`ACS_RPM]); // see (RULE5)
                    ch_ferr_ff <= !rx_ff; // see (RULE18)
                    ch_brk_ff <= !rx_ff && (sh_ff == 12'h000); // see (RULE21)
                    rx_st_ff <= (!rx_ff && sh_ff == 12'h000) ? R_BRK : R_IDLE;
                end
            end
            R_BRK: begin
                // Wait for the line to rise before hunting a start bit
                if (rx_ff) begin
                    rx_st_ff <= R_IDLE;
                end
            end
            default: rx_st_ff <= R_IDLE;
        endcase
    end
end

// ********
// Wakeup and descriptor decisions
// ********
logic hunt_ff;
logic closed_ff;
logic [3:0] fill_ff;
logic st_a_ff;
logic st_m_ff;
logic st_ov_ff;
logic [7:0] dstat_ff;
logic rx_event_ff;
logic [15:0] idle_cnt_ff;
logic [7:0] buf_mem [0:7];
logic hit1;
logic hit2;
logic do_store;
logic do_close;
logic cl_full;
logic cl_c;
logic cl_id;
logic cl_br;
logic set_afirst;
logic set_am;
logic resume;
logic go_hunt;
logic ovr;
logic resync_cmd;
logic release_cmd;

assign hit1 = ch_data_ff == match_first_ff;
assign hit2 = ch_data_ff == match_second_ff;
assign resync_cmd = wr && paddr == `ACS_A_CMD && pwdata[`ACS_CMD_RESYNC];
assign release_cmd = wr && paddr == `ACS_A_CMD && pwdata[`ACS_CMD_RELEASE];

always_comb begin
    do_store = 1'b0;
    do_close = 1'b0;
    cl_full = 1'b0;
    cl_c = 1'b0;
    cl_id = 1'b0;
    cl_br = 1'b0;
    set_afirst = 1'b0;
    set_am = 1'b0;
    resume = 1'b0;
    go_hunt = 1'b0;
    ovr = 1'b0;
    if (char_done_ff) begin
        if (hunt_ff) begin
            // Suspended: only a wakeup character is looked at
            if (um == 2'b01 && ch_abit_ff) begin
                resume = 1'b1; // see (RULE9)
                if (closed_ff) begin
                    ovr = 1'b1;
                end else begin
                    do_store = 1'b1;
                    set_afirst = 1'b1; // see (RULE13)
                end
            end else if (um == 2'b11 && ch_abit_ff && (hit1 || hit2)) begin
                resume = 1'b1;
                set_am = 1'b1; // see (RULE14)
            end
        end else if (closed_ff) begin
            ovr = 1'b1; // see (RULE20)
        end else if (um == 2'b11 && ch_abit_ff) begin
            if (hit1 || hit2) begin
                set_am = 1'b1;
                do_close = fill_ff != 4'h0;
            end else begin
                go_hunt = 1'b1;
            end
        end else if (um == 2'b01 && ch_abit_ff && fill_ff != 4'h0) begin
            // Address mid-buffer: close it, the address is lost
            do_close = 1'b1;
            ovr = 1'b1;
        end else if (ch_brk_ff) begin
            cl_br = fill_ff != 4'h0; // see (RULE17)
            do_close = cl_br;
        end else begin
            do_store = 1'b1;
            set_afirst = um == 2'b01 && ch_abit_ff;
        end
    end
    if (do_store) begin
        cl_full = (4'(fill_ff + 4'h1) == desc_ctl_ff[3:0]) ||
            fill_ff == 4'h7;
        cl_c = ctrl_char_ff[`ACS_CTRL_EN] &&
            ch_data_ff == ctrl_char_ff[7:0]; // see (RULE12)
        do_close = cl_full | cl_c | ch_ferr_ff | ch_perr_ff;
    end
    if (idle_seq_ff) begin
        if (hunt_ff) begin
            resume = um == 2'b00; // see (RULE2)
        end else if (!closed_ff && fill_ff != 4'h0 &&
                     idle_cnt_ff + 16'h0001 >= idle_close_count_ff) begin
            do_close = 1'b1;
            cl_id = 1'b1; // see (RULE16)
        end
    end
end

// ********
// Descriptor state and hunt
// ********
always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        hunt_ff <= 1'b0;
        closed_ff <= 1'b0;
        fill_ff <= 4'h0;
        st_a_ff <= 1'b0;
        st_m_ff <= 1'b0;
        st_ov_ff <= 1'b0;
        dstat_ff <= 8'h00;
        idle_cnt_ff <= 16'h0000;
    end else if (ce) begin
        if (resync_cmd) begin
            // Partial message is thrown away
            hunt_ff <= 1'b1; // see (RULE1) (RULE2)
            if (!closed_ff) begin
                fill_ff <= 4'h0;
            end
            st_a_ff <= 1'b0;
            st_m_ff <= 1'b0;
            idle_cnt_ff <= 16'h0000;
        end else begin
            if (resume) begin
                hunt_ff <= 1'b0; // see (RULE1) (RULE7)
            end else if (go_hunt) begin
                hunt_ff <= 1'b1;
            end
            if (do_store) begin
                fill_ff <= fill_ff + 4'h1; // see (RULE22)
            end
            if (do_close) begin
                closed_ff <= 1'b1;
                dstat_ff <= {cl_c, st_a_ff | set_afirst, st_m_ff, cl_id,
                    cl_br, do_store & ch_ferr_ff, do_store & ch_perr_ff,
                    st_ov_ff | ovr}; // see (RULE18) (RULE19) (RULE20)
                st_a_ff <= set_am;
                st_m_ff <= set_am & hit1; // see (RULE15)
                st_ov_ff <= 1'b0;
            end else begin
                if (set_am) begin
                    st_a_ff <= 1'b1; // see (RULE14)
                    st_m_ff <= hit1; // see (RULE15)
                end else if (set_afirst) begin
                    st_a_ff <= 1'b1;
                end
                if (ovr) begin
                    st_ov_ff <= 1'b1;
                end
            end
            if (release_cmd && closed_ff) begin
                closed_ff <= 1'b0;
                fill_ff <= 4'h0;
            end
            if (char_done_ff) begin
                idle_cnt_ff <= 16'h0000;
            end else if (idle_seq_ff && fill_ff != 4'h0 &&
                         idle_cnt_ff != 16'hFFFF) begin
                idle_cnt_ff <= idle_cnt_ff + 16'h0001;
            end
        end
    end
end

// Receive event: set wins over software clear
always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        rx_event_ff <= 1'b0;
    end else if (ce) begin
        if (do_close && cl_full && desc_ctl_ff[`ACS_DESC_IRQ]) begin
            rx_event_ff <= 1'b1; // see (RULE11)
        end else if (wr && paddr == `ACS_A_STAT &&
                     pwdata[`ACS_ST_EV]) begin
            rx_event_ff <= 1'b0;
        end
    end
end

always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        for (int i = 0; i < 8; i++) begin
            buf_mem[i] <= 8'h00;
        end
    end else if (ce && do_store) begin
        buf_mem[fill_ff[2:0]] <= ch_data_ff;
    end
end

// ********
// Transmitter
// ********
acs_tx_state_t tx_st_ff;
logic [12:0] tx_sh_ff;
logic [3:0] tx_left_ff;
logic [15:0] tbaud_ff;
logic txd_ff;
logic [12:0] tx_frm;
logic [7:0] tx_d;
logic tx_par;
logic [3:0] tx_pos;

assign txd = txd_ff;
assign tx_d = mode_ff[`ACS_CL] ? pwdata[7:0] : {1'b0, pwdata[6:0]};

always_comb begin
    case (mode_ff[`ACS_TPM_HI:`ACS_TPM_LO])
        2'b00: tx_par = ~^tx_d; // see (RULE4)
        2'b01: tx_par = 1'b0;
        2'b10: tx_par = ^tx_d;
        default: tx_par = 1'b1;
    endcase
    tx_frm = 13'h1FFF;
    tx_frm[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
        if (4'(i) < dlen) begin
            tx_frm[i + 1] = tx_d[i];
        end
    end
    tx_pos = 4'(dlen + 4'h1);
    if (um[0]) begin
        tx_frm[tx_pos] = pwdata[8]; // see (RULE8)
        tx_pos = 4'(tx_pos + 4'h1);
    end
    if (parity_enable) begin
        tx_frm[tx_pos] = tx_par; // see (RULE6)
    end
end

always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        tx_st_ff <= T_IDLE;
        tx_sh_ff <= 13'h1FFF;
        tx_left_ff <= 4'h0;
        tbaud_ff <= 16'h0000;
        txd_ff <= 1'b1;
    end else if (ce) begin
        case (tx_st_ff)
            T_IDLE: begin
                // A write while busy is dropped
                if (wr && paddr == `ACS_A_TXD && mode_ff[`ACS_TXEN]) begin
                    tx_st_ff <= T_SHIFT;
                    tx_sh_ff <= {1'b1, tx_frm[12:1]};
                    txd_ff <= tx_frm[0];
                    tx_left_ff <= 4'(frame_len - 4'h1);
                    tbaud_ff <= div_ff;
                end
            end
            T_SHIFT: begin
                if (tbaud_ff != 16'h0000) begin
                    tbaud_ff <= tbaud_ff - 16'h0001;
                end else if (tx_left_ff == 4'h0) begin
                    tx_st_ff <= T_IDLE;
                end else begin
                    txd_ff <= tx_sh_ff[0];
                    tx_sh_ff <= {1'b1, tx_sh_ff[12:1]};
                    tx_left_ff <= tx_left_ff - 4'h1;
                    tbaud_ff <= div_ff;
                end
            end
            default: tx_st_ff <= T_IDLE;
        endcase
    end
end

// ********
// Configuration writes and read mux
// ********
always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        mode_ff <= `ACS_MODE_RST; // see (RULE3)
        match_first_ff <= 8'h00;
        match_second_ff <= 8'h00;
        idle_close_count_ff <= `ACS_IDLE_RST;
        ctrl_char_ff <= 9'h000;
        desc_ctl_ff <= `ACS_DESC_RST;
        div_ff <= `ACS_DIV_RST;
    end else if (ce && wr) begin
        if (paddr == `ACS_A_MODE) begin
            mode_ff <= pwdata[15:0] & `ACS_MODE_WMASK;
        end else if (paddr == `ACS_A_MATCH) begin
            match_first_ff <= pwdata[7:0];
            match_second_ff <= pwdata[15:8];
        end else if (paddr == `ACS_A_IDLE) begin
            idle_close_count_ff <= pwdata[15:0];
        end else if (paddr == `ACS_A_CTRL) begin
            ctrl_char_ff <= pwdata[8:0];
        end else if (paddr == `ACS_A_DESC) begin
            desc_ctl_ff <= {3'b000, pwdata[4:0]};
        end else if (paddr == `ACS_A_DIV) begin
            div_ff <= pwdata[15:0];
        end
    end
end

always_comb begin
    mapped = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr == `ACS_A_MODE) begin
        rd_data = {16'h0000, mode_ff};
    end else if (paddr == `ACS_A_CMD || paddr == `ACS_A_TXD) begin
        rd_data = 32'h0000_0000;
    end else if (paddr == `ACS_A_STAT) begin
        rd_data = {16'h0000, fill_ff, tx_st_ff == T_SHIFT, hunt_ff,
            rx_event_ff, closed_ff, dstat_ff};
    end else if (paddr == `ACS_A_MATCH) begin
        rd_data = {16'h0000, match_second_ff, match_first_ff};
    end else if (paddr == `ACS_A_IDLE) begin
        rd_data = {16'h0000, idle_close_count_ff};
    end else if (paddr == `ACS_A_CTRL) begin
        rd_data = {23'h00_0000, ctrl_char_ff};
    end else if (paddr == `ACS_A_DESC) begin
        rd_data = {24'h00_0000, desc_ctl_ff};
    end else if (paddr == `ACS_A_DIV) begin
        rd_data = {16'h0000, div_ff};
    end else if (buf_hit) begin
        rd_data = {24'h00_0000, buf_mem[paddr[4:2]]};
    end else begin
        mapped = 1'b0;
    end
end

// One wait-free access phase: answer in the cycle after setup
always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
        pready_ff <= setup;
        pslverr_ff <= setup & ~mapped;
        if (setup) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
        end
    end
end

endmodule : acs_uart_core
`default_nettype wire

// >>> verilog/acs_regs.svh
// Register offsets, field positions and reset values of the serial channel
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// Byte offsets on the APB
`define ACS_A_MODE 8'h00
`define ACS_A_CMD 8'h04
`define ACS_A_TXD 8'h08
`define ACS_A_STAT 8'h0C
`define ACS_A_MATCH 8'h10
`define ACS_A_IDLE 8'h14
`define ACS_A_CTRL 8'h18
`define ACS_A_DESC 8'h1C
`define ACS_A_DIV 8'h20
`define ACS_A_BUF_LO 8'h40
`define ACS_A_BUF_HI 8'h5C
// Mode register fields
`define ACS_TPM_HI 15
`define ACS_TPM_LO 14
`define ACS_RPM 13
`define ACS_PEN 12
`define ACS_UM_HI 11
`define ACS_UM_LO 10
`define ACS_CL 8
`define ACS_SL 6
`define ACS_TXEN 1
`define ACS_RXEN 0
`define ACS_MODE_RST 16'h0000
`define ACS_MODE_WMASK 16'hFFFF
// Command bits
`define ACS_CMD_RESYNC 0
`define ACS_CMD_RELEASE 1
// Status bits
`define ACS_ST_EV 9
`define ACS_ST_CLOSED 8
// Descriptor control, control character enable, divider and idle count reset values
`define ACS_DESC_IRQ 4
`define ACS_DESC_RST 8'h08
`define ACS_CTRL_EN 8
`define ACS_DIV_RST 16'h015B
`define ACS_IDLE_RST 16'h0001
`endif

// >>> verilog/acs_pkg.sv
// Types shared by the serial channel design
`default_nettype none
package acs_pkg;
    typedef enum logic [2:0] {
        R_IDLE, R_START, R_BITS, R_STOP, R_BRK
    } acs_rx_state_t;
    typedef enum logic {T_IDLE, T_SHIFT} acs_tx_state_t;
endpackage : acs_pkg
`default_nettype wire

// >>> test/acs_uart_core_assertions.sv
// Port-level concurrent checks of the serial channel
`default_nettype none
`include "acs_regs.svh"
module acs_uart_core_assertions (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial line
    input wire logic rxd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mode_ff;
    logic [15:0] div_ff;
    logic [15:0] low_ff;
    logic wr_ok;
    logic rd_mode;
    logic mapped;
    assign wr_ok = ce && pready && pwrite && !pslverr;
    assign rd_mode = pready && !pwrite && paddr == `ACS_A_MODE;
    assign mapped = paddr[1:0] == 2'b00 && (paddr <= `ACS_A_DIV ||
        (paddr >= `ACS_A_BUF_LO && paddr <= `ACS_A_BUF_HI));
    // Mirrors of mode and bit period, plus length of each low run on txd
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= 16'h0000;
            div_ff <= `ACS_DIV_RST;
            low_ff <= 16'h0000;
        end else begin
            low_ff <= txd ? 16'h0000 : low_ff + 16'h0001;
            if (wr_ok && paddr == `ACS_A_MODE) begin
                mode_ff <= pwdata[15:0];
            end
            if (wr_ok && paddr == `ACS_A_DIV) begin
                div_ff <= pwdata[15:0];
            end
        end
    end
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_pulse: assert property (s_setup |=> s_answer)
        else $error("no single pready after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address");
    a_err_zero: assert property (pready && pslverr |-> prdata == 0)
        else $error("refused access returned data");
    a_write_zero: assert property (pready && pwrite |-> prdata == 0)
        else $error("write returned data");
    a_mode_readback: assert property (
        rd_mode |-> prdata == {16'h0000, mode_ff})
        else $error("mode register readback wrong");
    a_txd_bit_len: assert property (
        $rose(txd) |-> low_ff % (div_ff + 16'h0001) == 16'h0000)
        else $error("txd low run not whole bits");
    a_rst_quiet: assert property ($rose(rst_b) |-> !pready && txd)
        else $error("outputs not quiet after reset");
endmodule : acs_uart_core_assertions
bind acs_uart_core acs_uart_core_assertions acs_chk (.mclk, .rst_b,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rxd, .txd);
`default_nettype wire

// >>> test/acs_remote_station.sv
// Remote asynchronous station on the far end of the serial line
`default_nettype none
module acs_remote_station #(
    parameter int BIT = 4
) (
    // Clock
    input wire logic mclk,
    // Serial line
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial rxd = 1'b1;
    // Frame goes out LSB first, then the line idles high
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge mclk);
        end
        rxd <= 1'b1;
    endtask : send
    // Bounded hunt for a start bit, then mid-bit samples
    task automatic grab(input int n, output logic [11:0] f);
        int k;
        k = 0;
        while (txd && k < 4000) begin
            @(posedge mclk);
            k++;
        end
        repeat (BIT / 2) @(posedge mclk);
        f = 12'h000;
        for (int i = 0; i < n; i++) begin
            f[i] = txd;
            repeat (BIT) @(posedge mclk);
        end
    endtask : grab
endmodule : acs_remote_station
`default_nettype wire

// >>> test/acs_uart_core_tb.sv
// Self-checking bench of the serial channel
`default_nettype none
`include "acs_regs.svh"
module acs_uart_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BIT = 4;
    localparam logic [31:0] RX_ST [5] = '{32'h0000_0300, 32'h0000_0100,
        32'h0000_0102, 32'h0000_0104, 32'h0000_0180};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic txd;
    logic [31:0] rd;
    logic er;
    logic [11:0] fr;
    logic [15:0] rnd = 16'h24A7;
    logic [7:0] d;
    logic p;
    logic rx_parity_select;
    int error_cnt = 0;
    int checks_done = 0;
    always #12.5 mclk = ~mclk;
    acs_uart_core acs_uart_core_inst (.mclk, .rst_b, .ce, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rxd, .txd);
    acs_remote_station #(.BIT(BIT)) acs_remote_station_inst (.mclk,
        .txd, .rxd);
    // ********
    // Helpers
    // ********
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic tpar(input logic [7:0] v,
        input logic [1:0] t);
        return t[0] ? t[1] : (t[1] ? ^v : ~^v);
    endfunction : tpar
    task automatic end_sim;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] got,
        input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Idle edge first: psel never driven twice in a step
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rx_case(input logic [11:0] f, input logic [31:0] st);
        acs_remote_station_inst.send(f, 11);
        repeat (2 * BIT) @(posedge mclk);
        apb(1'b0, `ACS_A_STAT, 32'h0);
        chk("rx status", rd & 32'h0000_03FF, st);
        apb(1'b0, `ACS_A_BUF_LO, 32'h0);
        chk("rx byte", rd, {24'h0, d});
        apb(1'b1, `ACS_A_CMD, 32'h0000_0002);
        apb(1'b1, `ACS_A_STAT, 32'h0000_0200);
    endtask : rx_case
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, `ACS_A_MODE, 32'h0);
        chk("mode reset", rd, 32'h0);
        rnd = lfsr(rnd);
        apb(1'b1, `ACS_A_MODE, {16'h0, rnd});
        apb(1'b0, `ACS_A_MODE, 32'h0);
        chk("mode rw", rd, {16'h0, rnd});
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        apb(1'b1, `ACS_A_DIV, 32'h0000_0003);
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0];
            p = tpar(d, i < 4 ? i[1:0] : 2'b10);
            apb(1'b1, `ACS_A_MODE, i < 4 ? {16'h0, i[1:0], 14'h1102}
                : 32'h0000_9502);
            fork
                apb(1'b1, `ACS_A_TXD, {23'h0, rnd[8], d});
                acs_remote_station_inst.grab(i < 4 ? 11 : 12, fr);
            join
            chk("tx frame", {20'h0, fr}, i < 4
                ? {21'h0, 1'b1, p, d, 1'b0}
                : {20'h0, 1'b1, p, rnd[8], d, 1'b0});
        end
        rnd = lfsr(rnd);
        rx_parity_select = rnd[0];
        apb(1'b1, `ACS_A_MODE, {16'h0, 2'b00, rx_parity_select, 13'h1101});
        for (int k = 0; k < 5; k++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0] | 8'h01;
            p = tpar(d, {rx_parity_select, 1'b0});
            apb(1'b1, `ACS_A_DESC, k == 0 ? 32'h11 : k == 1 ? 32'h01
                : 32'h10);
            apb(1'b1, `ACS_A_CTRL, k == 4 ? {23'h1, d} : 32'h0);
            rx_case({1'b1 ^ (k == 3), p ^ (k == 2), d, 1'b0},
                RX_ST[k]);
        end
        apb(1'b1, `ACS_A_CTRL, 32'h0);
        apb(1'b1, `ACS_A_CMD, 32'h0000_0001);
        apb(1'b0, `ACS_A_STAT, 32'h0);
        chk("hunting", rd & 32'h400, 32'h400);
        rnd = lfsr(rnd);
        d = rnd[7:0] | 8'h01;
        p = tpar(d, {rx_parity_select, 1'b0});
        acs_remote_station_inst.send({1'b1, p, d, 1'b0}, 11);
        repeat (2 * BIT) @(posedge mclk);
        apb(1'b0, `ACS_A_STAT, 32'h0);
        chk("hunt drop", rd & 32'hF1FF, 32'h80);
        repeat (16 * BIT) @(posedge mclk);
        apb(1'b0, `ACS_A_STAT, 32'h0);
        chk("woken", rd & 32'h400, 32'h0);
        acs_remote_station_inst.send({1'b1, p, d, 1'b0}, 11);
        repeat (2 * BIT) @(posedge mclk);
        apb(1'b0, `ACS_A_BUF_LO, 32'h0);
        chk("resumed", rd, {24'h0, d});
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end
endmodule : acs_uart_core_tb
`default_nettype wire
